// ### rtl/eep_pkg.sv
// Shared constants, types and helpers for the serial EEPROM bus target
package eep_pkg;

  // Array geometry
  localparam int EEP_ADDR_W = 15;
  localparam int EEP_OFS_W = 6;
  localparam int EEP_PAGE_W = 9;
  localparam int EEP_PAGES = 512;
  localparam int EEP_PAGE_BYTES = 64;
  localparam int EEP_BYTES = EEP_PAGES * EEP_PAGE_BYTES;

  // Device address byte layout
  localparam logic [3:0] EEP_CLASS_CODE = 4'ha;
  localparam int EEP_CLASS_MSB = 7;
  localparam int EEP_CLASS_LSB = 4;
  localparam int EEP_SEL_MSB = 3;
  localparam int EEP_SEL_LSB = 1;
  localparam int EEP_RW_BIT = 0;
  localparam int EEP_AHI_MSB = 6;

  // Bit slots within one nine-clock byte frame
  localparam logic [3:0] EEP_LAST_BIT = 4'h7;
  localparam logic [3:0] EEP_ACK_SLOT = 4'h8;

  // Reset values
  localparam logic [EEP_ADDR_W-1:0] EEP_ADDR_RST = 15'h0000;
  localparam logic [31:0] EEP_TIMER_RST = 32'h0000_0000;

  // Self-timed programming cycle, longest time rounded down
  localparam longint EEP_CORE_CLK_HZ = 20_000_000;
  localparam longint EEP_T_PROG_US = 5000;
  localparam longint EEP_PROG_CYCLES_L = EEP_T_PROG_US * EEP_CORE_CLK_HZ / 1_000_000;
  localparam int unsigned EEP_PROG_CYCLES = 32'(EEP_PROG_CYCLES_L);

  // Protocol phases at the link
  typedef enum logic [2:0] {
    EEP_ST_IDLE,
    EEP_ST_DEV,
    EEP_ST_AHI,
    EEP_ST_ALO,
    EEP_ST_WDATA,
    EEP_ST_RDATA
  } eep_state_t;

  // Floating or unknown pin reads as low, like an internal pull-down
  function automatic logic eep_level(input logic pin);
    logic v;
    v = 1'b0;
    case (pin)
      1'b1: v = 1'b1;
      default: v = 1'b0;
    endcase
    return v;
  endfunction : eep_level

endpackage : eep_pkg

// ### rtl/eep_prog.sv
// Programming engine: array storage, commit on STOP and self-timed write cycle
module eep_prog
  import eep_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = EEP_PROG_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic write_protect,
  eep_prog_if.prog pif
);

  typedef struct packed {
    logic stop_m;
    logic stop_s;
    logic stop_last;
    logic wr_m;
    logic wr_s;
    logic wr_done;
    logic wp_m;
    logic wp_s;
    logic busy;
    logic [31:0] timer;
  } eep_prog_st_t;

  localparam eep_prog_st_t EEP_PROG_RST = '{
    stop_m: 1'b0, stop_s: 1'b0, stop_last: 1'b0, wr_m: 1'b0, wr_s: 1'b0,
    wr_done: 1'b0, wp_m: 1'b0, wp_s: 1'b0, busy: 1'b0, timer: EEP_TIMER_RST};

  eep_prog_st_t r, n;
  logic commit;
  logic [7:0] mem [EEP_BYTES];

  // STOP seen with an unconsumed write frame and no cycle running
  assign commit = (r.stop_s != r.stop_last) && (r.wr_s != r.wr_done) && !r.busy;

  // Synchronisers, commit decision and cycle timer
  always_comb begin
    n = r;
    n.stop_m = pif.stop_tog;
    n.stop_s = r.stop_m;
    n.wr_m = pif.wr_tog;
    n.wr_s = r.wr_m;
    n.wp_m = eep_level(write_protect);
    n.wp_s = r.wp_m;
    n.stop_last = r.stop_s;
    if (commit) begin
      n.wr_done = r.wr_s;
      if (!r.wp_s) begin
        n.busy = 1'b1;
        n.timer = 32'(PROG_CYCLES - 1);
      end
    end else if (r.busy) begin
      // Busy drops after the full cycle count, then standby
      if (r.timer == EEP_TIMER_RST) begin
        n.busy = 1'b0;
      end else begin
        n.timer = r.timer - 32'h1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r <= EEP_PROG_RST;
    end else begin
      r <= n;
    end
  end

  // Whole page lands in one cycle; only bytes received in the frame change
  always_ff @(posedge core_clk) begin
    if (commit && !r.wp_s) begin
      for (int i = 0; i < EEP_PAGE_BYTES; i++) begin
        if (pif.mask[i]) begin
          mem[{pif.page, EEP_OFS_W'(i)}] <= pif.pbuf[i];
        end
      end
    end
  end

  // Link only reads while no cycle runs, so the array is quiet then
  assign pif.rd_data = mem[pif.rd_addr];
  assign pif.busy = r.busy;

endmodule : eep_prog

// ### rtl/eep_prog_if.sv
// Crossing signals between the link engine and the programming engine
interface eep_prog_if;
  import eep_pkg::*;

  logic stop_tog;
  logic wr_tog;
  logic [EEP_PAGE_W-1:0] page;
  logic [EEP_PAGE_BYTES-1:0][7:0] pbuf;
  logic [EEP_PAGE_BYTES-1:0] mask;
  logic [EEP_ADDR_W-1:0] rd_addr;
  logic [7:0] rd_data;
  logic busy;

  modport link (
    output stop_tog,
    output wr_tog,
    output page,
    output pbuf,
    output mask,
    output rd_addr,
    input rd_data,
    input busy
  );

  modport prog (
    input stop_tog,
    input wr_tog,
    input page,
    input pbuf,
    input mask,
    input rd_addr,
    output rd_data,
    output busy
  );
endinterface : eep_prog_if

// ### rtl/eep_target.sv
// Two-wire bus target of a 32K-by-8 serial EEPROM, link side and top level
//
// Behaviour
// - Sample on clock rise, drive on fall
// - Floating strap inputs count as low
// - Data line open-drain, never driven high
// - Write-protect high blocks all programming
// - 512 pages of 64 bytes, 15-bit address
// - Data falling with clock high is START
// - Data rising with clock high is STOP
// - STOP after write starts timed programming
// - Acknowledge each byte on ninth clock
// - Standby after reset, read STOP, programming
// - Upper four address bits must match class
// - Strap mismatch means no acknowledge, standby
// - Eighth address bit selects read or write
// - Byte write: address, two words, data, STOP
// - Ignore the bus while programming runs
// - Page write takes up to 64 bytes
// - Written data bytes bump only low six address bits
// - No address acknowledge while programming
// - Counter holds last address plus one
// - Master ack continues read; counter wraps
// - Restart after address words abandons write
module eep_target
  import eep_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = EEP_PROG_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic chip_select_strap_0,
  input wire logic chip_select_strap_1,
  input wire logic chip_select_strap_2,
  input wire logic write_protect
);

  // Link state, all of it clocked by the rising bus clock
  typedef struct packed {
    eep_state_t st;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [EEP_ADDR_W-1:0] addr;
    logic ack;
    logic [EEP_PAGE_BYTES-1:0][7:0] pbuf;
    logic [EEP_PAGE_BYTES-1:0] mask;
    logic wr_open;
    logic wr_tog;
    logic start_seen;
    logic stop_seen;
    logic busy_m;
    logic busy_s;
    logic [2:0] strap_m;
    logic [2:0] strap_s;
  } eep_link_t;

  localparam eep_link_t EEP_LINK_RST = '{
    st: EEP_ST_IDLE,
    cnt: 4'h0,
    shreg: 8'h00,
    tx: 8'h00,
    addr: EEP_ADDR_RST,
    ack: 1'b0,
    pbuf: '0,
    mask: '0,
    wr_open: 1'b0,
    wr_tog: 1'b0,
    start_seen: 1'b0,
    stop_seen: 1'b0,
    busy_m: 1'b0,
    busy_s: 1'b0,
    strap_m: 3'h0,
    strap_s: 3'h0
  };

  eep_link_t r, n;
  logic start_tog_r;
  logic stop_tog_r;
  logic sda_oe_r;
  logic start_pend;
  logic stop_since;
  logic [7:0] rx_byte;
  logic [2:0] strap_lvl;
  logic dev_match;
  logic oe_nxt;

  eep_prog_if pif ();

  // START: data falls while the clock is high; toggle marks each event
  always_ff @(negedge sda_in or posedge rst) begin
    if (rst) begin
      start_tog_r <= 1'b0;
    end else if (scl) begin
      start_tog_r <= ~start_tog_r;
    end
  end

  // STOP: data rises while the clock is high; no clock edge follows it
  always_ff @(posedge sda_in or posedge rst) begin
    if (rst) begin
      stop_tog_r <= 1'b0;
    end else if (scl) begin
      stop_tog_r <= ~stop_tog_r;
    end
  end

  // Master holds data steady through the rising clock, so a pending
  // toggle is settled by the first rise after the condition
  assign start_pend = (start_tog_r != r.start_seen);
  assign stop_since = (stop_tog_r != r.stop_seen);
  assign rx_byte = {r.shreg[6:0], sda_in};

  // Strap levels, floating pins read low
  assign strap_lvl = {eep_level(chip_select_strap_2), eep_level(chip_select_strap_1),
                      eep_level(chip_select_strap_0)};

  // Class code, strap match and no cycle in progress
  assign dev_match = (rx_byte[EEP_CLASS_MSB:EEP_CLASS_LSB] == EEP_CLASS_CODE) &&
                     (rx_byte[EEP_SEL_MSB:EEP_SEL_LSB] == r.strap_s) &&
                     !r.busy_s;

  // Protocol engine, one step per rising bus clock
  always_comb begin
    n = r;
    n.busy_m = pif.busy;
    n.busy_s = r.busy_m;
    n.strap_m = strap_lvl;
    n.strap_s = r.strap_m;
    if (start_pend) begin
      // First rise after START carries the device address MSB
      n.start_seen = start_tog_r;
      n.stop_seen = stop_tog_r;
      if (r.wr_open && !stop_since) begin
        n.wr_tog = ~r.wr_tog;
      end
      n.wr_open = 1'b0;
      n.mask = '0;
      n.ack = 1'b0;
      n.st = EEP_ST_DEV;
      n.cnt = 4'h1;
      n.shreg = {7'h00, sda_in};
    end else if (r.st == EEP_ST_IDLE) begin
      // Standby: everything ignored until the next START
      n.cnt = 4'h0;
    end else if (r.cnt != EEP_ACK_SLOT) begin
      // Data bits of a byte frame
      n.cnt = r.cnt + 4'h1;
      n.shreg = rx_byte;
      n.tx = {r.tx[6:0], 1'b0};
      if (r.cnt == EEP_LAST_BIT) begin
        unique case (r.st)
          EEP_ST_DEV: begin
            n.ack = dev_match;
          end
          EEP_ST_AHI: begin
            n.addr[EEP_ADDR_W-1:8] = rx_byte[EEP_AHI_MSB:0];
            n.ack = 1'b1;
          end
          EEP_ST_ALO: begin
            n.addr[7:0] = rx_byte;
            n.ack = 1'b1;
          end
          EEP_ST_WDATA: begin
            n.pbuf[r.addr[EEP_OFS_W-1:0]] = rx_byte;
            n.mask[r.addr[EEP_OFS_W-1:0]] = 1'b1;
            n.addr[EEP_OFS_W-1:0] = r.addr[EEP_OFS_W-1:0] + 6'h01;
            n.ack = 1'b1;
            if (!r.wr_open) begin
              n.wr_open = 1'b1;
              n.wr_tog = ~r.wr_tog;
            end
          end
          EEP_ST_RDATA: begin
            n.ack = 1'b0;
          end
          default: begin
            n.ack = 1'b0;
          end
        endcase
      end
    end else begin
      // Ninth clock: acknowledge slot and the phase step
      n.cnt = 4'h0;
      n.ack = 1'b0;
      unique case (r.st)
        EEP_ST_DEV: begin
          if (!r.ack) begin
            n.st = EEP_ST_IDLE;
          end else if (r.shreg[EEP_RW_BIT]) begin
            n.st = EEP_ST_RDATA;
            n.tx = pif.rd_data;
            n.addr = r.addr + 15'h0001;
          end else begin
            n.st = EEP_ST_AHI;
          end
        end
        EEP_ST_AHI: begin
          n.st = EEP_ST_ALO;
        end
        EEP_ST_ALO: begin
          n.st = EEP_ST_WDATA;
        end
        EEP_ST_WDATA: begin
          n.st = EEP_ST_WDATA;
        end
        EEP_ST_RDATA: begin
          // Low from the master asks for the next byte
          if (sda_in) begin
            n.st = EEP_ST_IDLE;
          end else begin
            n.tx = pif.rd_data;
            n.addr = r.addr + 15'h0001;
          end
        end
        default: begin
          n.st = EEP_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      r <= EEP_LINK_RST;
    end else begin
      r <= n;
    end
  end

  // Data line drive decided for the low half of the clock
  always_comb begin
    oe_nxt = 1'b0;
    if (!start_pend) begin
      if (r.cnt == EEP_ACK_SLOT) begin
        oe_nxt = r.ack;
      end else if (r.st == EEP_ST_RDATA) begin
        oe_nxt = !r.tx[7];
      end
    end
  end

  // Output changes on the falling clock, well clear of the master's sample
  always_ff @(negedge scl or posedge rst) begin
    if (rst) begin
      sda_oe_r <= 1'b0;
    end else begin
      sda_oe_r <= oe_nxt;
    end
  end

  // Open drain: pull low or release, never a driven high
  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_r;

  // Frame contents stay put from the last clock edge until the next START,
  // which is what lets the other domain read them after STOP
  assign pif.stop_tog = stop_tog_r;
  assign pif.wr_tog = r.wr_tog;
  assign pif.page = r.addr[EEP_ADDR_W-1:EEP_OFS_W];
  assign pif.pbuf = r.pbuf;
  assign pif.mask = r.mask;
  assign pif.rd_addr = r.addr;

  eep_prog #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_prog (
    .core_clk(core_clk),
    .rst(rst),
    .write_protect(write_protect),
    .pif(pif)
  );

endmodule : eep_target

// ### testbench/eep_checker.sv
// Pin-level protocol checker for the EEPROM bus target
module eep_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic chip_select_strap_0,
  input wire logic chip_select_strap_1,
  input wire logic chip_select_strap_2
);
  logic tog_r, seen_r, first_r, wr_r, rd_r, off_r;
  logic [3:0] bc_r;
  logic [7:0] sh_r;
  // START flips a toggle, noticed at the next clock rise
  always_ff @(negedge sda_in or posedge rst) begin
    if (rst) tog_r <= 1'b0;
    else if (scl) tog_r <= ~tog_r;
  end
  // Bit slot, last eight bits and mode of the frame
  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      {seen_r, first_r, wr_r, rd_r, off_r, bc_r, sh_r} <= '0;
    end else begin
      seen_r <= tog_r;
      sh_r <= {sh_r[6:0], sda_in};
      bc_r <= (bc_r == 4'h9) ? 4'h1 : bc_r + 4'h1;
      if (first_r && bc_r == 4'h8) begin
        {first_r, wr_r, rd_r, off_r} <= {1'b0, sda_oe & ~sh_r[0], sda_oe & sh_r[0], ~sda_oe};
      end
      // A new START wins over any slot bookkeeping
      if (seen_r != tog_r) begin
        {first_r, wr_r, rd_r, off_r, bc_r} <= 8'h81;
      end
    end
  end
  out_low_a: assert property (@(posedge core_clk) disable iff (rst) !sda_out)
    else $error("data driven high");
  oe_edge_a: assert property (@(posedge core_clk) disable iff (rst)
    $changed(sda_oe) |-> !scl) else $error("data moved with clock high");
  standby_rst_a: assert property (@(posedge core_clk) disable iff (rst)
    $fell(rst) |-> !sda_oe) else $error("line pulled after reset");
  addr_match_a: assert property (@(posedge scl) disable iff (rst)
    first_r && bc_r == 4'h8 && sda_oe |-> sh_r[7:4] == 4'ha
    && sh_r[3:1] == {chip_select_strap_2, chip_select_strap_1, chip_select_strap_0})
    else $error("address acked without match");
  addr_quiet_a: assert property (@(posedge scl) disable iff (rst)
    first_r && bc_r < 4'h8 |-> !sda_oe) else $error("line pulled in address");
  data_ack_a: assert property (@(posedge scl) disable iff (rst)
    wr_r && bc_r == 4'h8 |-> sda_oe ##1 !sda_oe [*8]) else $error("write ack wrong");
  rd_release_a: assert property (@(posedge scl) disable iff (rst)
    rd_r && bc_r == 4'h8 |-> !sda_oe) else $error("master slot held");
  nak_quiet_a: assert property (@(posedge scl) disable iff (rst)
    off_r |-> !sda_oe) else $error("line pulled after refusal");
endmodule : eep_checker

// ### testbench/eep_mst.sv
// Bus master model: clocks frames and pulls the data line low
module eep_mst (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 10ps;
  // Clock stands high and the line is released between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // One 125 ns clock: data set while low, line read at end of high
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    #31.25;
    scl = 1'b1;
    #62.5;
    r = sda;
    scl = 1'b0;
    #31.25;
  endtask : bit_io
  // START, also a repeated START from a low clock
  task automatic start();
    sda_low = 1'b0;
    #31.25;
    scl = 1'b1;
    #62.5;
    sda_low = 1'b1;
    #62.5;
    scl = 1'b0;
    #31.25;
  endtask : start
  // STOP, then bus free time before the next START
  task automatic stop();
    sda_low = 1'b1;
    #31.25;
    scl = 1'b1;
    #62.5;
    sda_low = 1'b0;
    #600;
  endtask : stop
  // Byte MSB first, then the ninth clock; nine high leaves it released
  task automatic xfer(input logic [7:0] d, input logic nine, output logic [7:0] q,
    output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(nine, r);
    ack = ~r;
  endtask : xfer
endmodule : eep_mst

// ### testbench/eep_target_tb.sv
// Self-checking bench: master model against the EEPROM bus target
module eep_target_tb;
  timeunit 1ns;
  timeprecision 10ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic wp = 1'b0;
  logic [2:0] strap = 3'h5;
  logic scl, sda_low, sda_oe;
  int fail_count = 0;
  int compares = 0;
  // Open-drain line with pull-up
  wire logic sda = ~(sda_low | sda_oe);
  eep_target #(.PROG_CYCLES(100)) eep_target_inst (.core_clk, .rst, .scl, .sda_in(sda),
    .sda_out(), .sda_oe, .chip_select_strap_0(strap[0]), .chip_select_strap_1(strap[1]),
    .chip_select_strap_2(strap[2]), .write_protect(wp));
  eep_mst eep_mst_inst (.scl, .sda_low, .sda);
  always #25 core_clk = ~core_clk;
  task automatic results();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One byte from the master, acknowledge compared
  task automatic wb(input logic [7:0] d, input logic ack);
    logic [7:0] q;
    logic a;
    eep_mst_inst.xfer(d, 1'b1, q, a);
    chk("ack", {7'h0, ack}, {7'h0, a});
  endtask : wb
  task automatic addr(input logic [14:0] a);
    eep_mst_inst.start();
    wb(8'haa, 1'b1);
    wb({1'b0, a[14:8]}, 1'b1);
    wb(a[7:0], 1'b1);
  endtask : addr
  task automatic wframe(input logic [14:0] a, input int n, input logic [7:0] d0);
    addr(a);
    for (int i = 0; i < n; i++) wb(d0 + 8'(i), 1'b1);
    eep_mst_inst.stop();
  endtask : wframe
  // Address load, restart, sequential read, no ack on the last byte
  task automatic rd_chk(input logic [14:0] a, input logic [7:0] e [$]);
    logic [7:0] q;
    logic k;
    addr(a);
    eep_mst_inst.start();
    wb(8'hab, 1'b1);
    foreach (e[i]) begin
      eep_mst_inst.xfer(8'hff, 1'(i == e.size() - 1), q, k);
      chk("read", e[i], q);
    end
    eep_mst_inst.stop();
  endtask : rd_chk
  // Bounded acknowledge polling; first try shows the busy state
  task automatic poll(input logic busy);
    logic [7:0] q;
    logic a;
    a = 1'b0;
    for (int n = 0; n < 40 && a !== 1'b1; n++) begin
      eep_mst_inst.start();
      eep_mst_inst.xfer(8'haa, 1'b1, q, a);
      eep_mst_inst.stop();
      if (n == 0) chk("busy", {7'h0, busy}, {7'h0, ~a});
    end
    if (a !== 1'b1) begin
      chk("poll", 8'h01, 8'h00);
      results();
    end
  endtask : poll
  task automatic t_addr();
    logic [7:0] bad [3] = '{8'h2a, 8'ha0, 8'hae};
    foreach (bad[i]) begin
      eep_mst_inst.start();
      wb(bad[i], 1'b0);
      eep_mst_inst.stop();
    end
  endtask : t_addr
  // 65 bytes wrap inside page 0; byte at the top, read wraps to zero
  task automatic t_page();
    logic [7:0] e [$];
    for (int o = 0; o < 64; o++)
      e.push_back(8'h10 + 8'((o + 2) % 64) + (o == 62 ? 8'h40 : 8'h00));
    wframe(15'h003e, 65, 8'h10);
    poll(1'b1);
    rd_chk(15'h0000, e);
    wframe(15'h7fff, 1, 8'h5a);
    poll(1'b1);
    rd_chk(15'h7fff, {8'h5a, e[0]});
  endtask : t_page
  // Protected write leaves no busy time and old data
  task automatic t_wp();
    @(posedge core_clk);
    #1 wp = 1'b1;
    wframe(15'h7fff, 1, 8'ha5);
    poll(1'b0);
    rd_chk(15'h7fff, {8'h5a});
  endtask : t_wp
  initial begin
    repeat (16) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge core_clk);
    t_addr();
    t_page();
    t_wp();
    results();
  end
endmodule : eep_target_tb
bind eep_target eep_checker eep_checker_inst (.core_clk, .rst, .scl, .sda_in, .sda_out,
  .sda_oe, .chip_select_strap_0, .chip_select_strap_1, .chip_select_strap_2);
